// ==== bench/mbmie_apb_master.sv ====
module mbmie_apb_master (
  input wire logic pclk, // Bus clock
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Slave ready
  input wire logic pslverr, // Slave error
  output logic psel, // Select
  output logic penable, // Enable
  output logic pwrite, // Direction
  output logic [7:0] paddr, // Byte address
  output logic [31:0] pwdata // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; the leading edge keeps back-to-back calls from driving twice at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e, output logic ok);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    q = prdata;
    e = pslverr;
    ok = pready;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ==== bench/mbmie_exec_sva.sv ====
module mbmie_exec_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic global_int_en // Interrupt enable
);
  // Helper terms; a ret or return_from_interrupt retires up to three edges after its write
  logic wr_done;
  logic ctl_wr;
  logic ins_wr;
  logic gie_bit;
  assign wr_done = pready & pwrite;
  assign ctl_wr = wr_done & ~pslverr & (paddr == mbmie_pkg::OFF_CTRL);
  assign ins_wr = wr_done & ~pslverr & (paddr == mbmie_pkg::OFF_INSTR);
  assign gie_bit = pwdata[mbmie_pkg::CTL_GIE];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready) else $error("no wait state");
  a_read_bound: assert property (psel && penable && !pwrite |-> ##[0:3] pready) else $error("read stalled");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("read data not zero");
  a_unmapped_err: assert property (pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0) else $error("no error");
  a_mapped_ok: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
  a_return_from_interrupt_gie: assert property (ins_wr && pwdata[31:27] == 5'h17 |-> ##[1:3] global_int_en)
    else $error("return_from_interrupt left enable low");
  a_ret_keeps: assert property (ins_wr && pwdata[31:27] == 5'h16 |=> $stable(global_int_en)[*3])
    else $error("ret moved enable");
  a_ctrl_gie: assert property (ctl_wr |=> global_int_en == $past(gie_bit)) else $error("enable not written");
  a_gie_cause: assert property ($changed(global_int_en) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("enable moved alone");
endmodule

bind mbmie_exec mbmie_exec_sva mbmie_exec_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .global_int_en);

// ==== bench/mcu_branch_misc_instr_exec_tb_top.sv ====
module mcu_branch_misc_instr_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic global_int_en;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  int miscompares = 0;
  int compares = 0;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  mbmie_apb_master mbmie_apb_master_inst (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  mbmie_exec mbmie_exec_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .global_int_en);
  task summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  // A hung slave ends the run at once
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    logic ok;
    mbmie_apb_master_inst.xfer(w, a, d, q, e, ok);
    if (ok !== 1'b1)
    begin
      $display("unexpected pready at %h expected 1 seen %b", a, ok);
      miscompares++;
      summarize();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask
  task chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0, q, e);
    cmp($sformatf("register %h", a), exp, q);
  endtask
  task acc(input logic [31:0] x);
    chk(mbmie_pkg::OFF_ACC, x);
  endtask
  task flg(input logic [31:0] x);
    chk(mbmie_pkg::OFF_FLAGS, x);
  endtask
  task pcr(input logic [31:0] x);
    chk(mbmie_pkg::OFF_PC, x);
  endtask
  task cyc(input logic [31:0] x);
    chk(mbmie_pkg::OFF_CYCLES, x);
  endtask
  task setm(input logic [8:0] a, input logic [7:0] d);
    wr(mbmie_pkg::OFF_MADDR, {23'h0, a});
    wr(mbmie_pkg::OFF_MDATA, {24'h0, d});
  endtask
  task chkm(input logic [8:0] a, input logic [7:0] d);
    wr(mbmie_pkg::OFF_MADDR, {23'h0, a});
    chk(mbmie_pkg::OFF_MDATA, {24'h0, d});
  endtask
  // Issue one instruction and poll busy, bounded
  task ex(input logic [4:0] op, input logic [2:0] b, input logic [15:0] v);
    logic [31:0] q;
    logic e;
    int n;
    wr(mbmie_pkg::OFF_INSTR, {op, b, 8'h00, v});
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 16)
    begin
      bus(1'b0, mbmie_pkg::OFF_STATUS, 32'h0, q, e);
      n++;
    end
    if (q[0] !== 1'b0)
    begin
      $display("unexpected busy expected 0 seen %b", q[0]);
      miscompares++;
      summarize();
    end
  endtask
  task s_reset;
    cmp("gie", 32'h0, {31'h0, global_int_en});
    acc(32'h00);
    flg(32'h00);
    pcr(32'h0000);
    cyc(32'h0);
    chk(mbmie_pkg::OFF_STATUS, 32'h0);
  endtask
  task s_compare;
    wr(mbmie_pkg::OFF_PC, 32'h0100);
    wr(mbmie_pkg::OFF_ACC, 32'h35);
    ex(mbmie_pkg::OP_CMP_I, 3'h0, 16'h0035);
    cyc(32'h2);
    flg(32'h05);
    pcr(32'h0102);
    ex(mbmie_pkg::OP_CMP_I, 3'h0, 16'h0036);
    cyc(32'h1);
    flg(32'h00);
    pcr(32'h0103);
    setm(9'h010, 8'h35);
    ex(mbmie_pkg::OP_CMP_M, 3'h0, 16'h0010);
    cyc(32'h2);
    flg(32'h05);
    acc(32'h35);
  endtask
  task s_incdec;
    wr(mbmie_pkg::OFF_FLAGS, 32'h02);
    setm(9'h020, 8'hFF);
    setm(9'h021, 8'h01);
    ex(mbmie_pkg::OP_INCREMENT_ACC_SKIP_ZERO, 3'h0, 16'h0020);
    acc(32'h00);
    cyc(32'h2);
    flg(32'h02);
    chkm(9'h020, 8'hFF);
    ex(mbmie_pkg::OP_INCREMENT_MEM_SKIP_ZERO, 3'h0, 16'h0020);
    cyc(32'h3);
    chkm(9'h020, 8'h00);
    ex(mbmie_pkg::OP_DECREMENT_ACC_SKIP_ZERO, 3'h0, 16'h0020);
    acc(32'hFF);
    cyc(32'h1);
    flg(32'h02);
    ex(mbmie_pkg::OP_DECREMENT_MEM_SKIP_ZERO, 3'h0, 16'h0021);
    cyc(32'h3);
    chkm(9'h021, 8'h00);
    setm(9'h090, 8'h05);
    ex(mbmie_pkg::OP_DECREMENT_MEM_SKIP_ZERO, 3'h0, 16'h0090);
    cyc(32'h1);
    chkm(9'h090, 8'h04);
  endtask
  task s_bits;
    setm(9'h030, 8'h00);
    ex(mbmie_pkg::OP_BIT_FORCE_HIGH, 3'h3, 16'h0030);
    cyc(32'h2);
    chkm(9'h030, 8'h08);
    ex(mbmie_pkg::OP_BIT_TEST_SKIP_SET, 3'h3, 16'h0030);
    cyc(32'h2);
    ex(mbmie_pkg::OP_BIT_TEST_SKIP_CLEAR, 3'h3, 16'h0030);
    cyc(32'h1);
    ex(mbmie_pkg::OP_BIT_FORCE_LOW, 3'h3, 16'h0030);
    chkm(9'h030, 8'h00);
    wr(mbmie_pkg::OFF_CTRL, 32'h1);
    setm(9'h130, 8'h00);
    ex(mbmie_pkg::OP_BANK0_BIT_FORCE_HIGH, 3'h5, 16'h0030);
    chkm(9'h030, 8'h20);
    chkm(9'h130, 8'h00);
    ex(mbmie_pkg::OP_BANK0_BIT_TEST_SKIP_SET, 3'h5, 16'h0030);
    cyc(32'h2);
    ex(mbmie_pkg::OP_BANK0_BIT_TEST_SKIP_CLEAR, 3'h5, 16'h0030);
    cyc(32'h1);
    ex(mbmie_pkg::OP_BIT_TEST_SKIP_CLEAR, 3'h5, 16'h0030);
    cyc(32'h2);
    ex(mbmie_pkg::OP_BANK0_BIT_FORCE_LOW, 3'h5, 16'h0030);
    chkm(9'h030, 8'h00);
    wr(mbmie_pkg::OFF_CTRL, 32'h0);
  endtask
  task s_rotate;
    wr(mbmie_pkg::OFF_FLAGS, 32'h01);
    setm(9'h040, 8'h81);
    ex(mbmie_pkg::OP_RRC, 3'h0, 16'h0040);
    acc(32'hC0);
    flg(32'h01);
    ex(mbmie_pkg::OP_ROTATE_LEFT_CARRY_TO_MEM, 3'h0, 16'h0040);
    chkm(9'h040, 8'h03);
    cyc(32'h2);
    wr(mbmie_pkg::OFF_FLAGS, 32'h00);
    ex(mbmie_pkg::OP_ROTATE_RIGHT_CARRY_TO_MEM, 3'h0, 16'h0040);
    chkm(9'h040, 8'h01);
    flg(32'h01);
    ex(mbmie_pkg::OP_RLC, 3'h0, 16'h0040);
    acc(32'h03);
    flg(32'h00);
    ex(mbmie_pkg::OP_CLR, 3'h0, 16'h0040);
    chkm(9'h040, 8'h00);
    ex(mbmie_pkg::OP_NOP, 3'h0, 16'h0000);
    acc(32'h03);
    cyc(32'h1);
  endtask
  task s_branch;
    wr(mbmie_pkg::OFF_CTRL, 32'h4);
    ex(mbmie_pkg::OP_JMP, 3'h0, 16'h1234);
    pcr(32'h9234);
    cyc(32'h2);
    ex(mbmie_pkg::OP_CALL, 3'h0, 16'h0010);
    pcr(32'h8010);
    chk(mbmie_pkg::OFF_STATUS, 32'h10);
    ex(mbmie_pkg::OP_RET, 3'h0, 16'h0000);
    pcr(32'h9235);
    cmp("gie", 32'h0, {31'h0, global_int_en});
    ex(mbmie_pkg::OP_CALL, 3'h0, 16'h3FFF);
    pcr(32'hBFFF);
    ex(mbmie_pkg::OP_RETURN_FROM_INTERRUPT, 3'h0, 16'h0000);
    pcr(32'h9236);
    cyc(32'h2);
    cmp("gie", 32'h1, {31'h0, global_int_en});
    wr(mbmie_pkg::OFF_CTRL, 32'h0);
  endtask
  task s_shadow;
    wr(mbmie_pkg::OFF_ACC, 32'h5A);
    wr(mbmie_pkg::OFF_FLAGS, 32'hC7);
    ex(mbmie_pkg::OP_PUSH, 3'h0, 16'h0000);
    cyc(32'h1);
    wr(mbmie_pkg::OFF_ACC, 32'h00);
    // Status bits set now must survive the restore, saved ones must not return
    wr(mbmie_pkg::OFF_FLAGS, 32'h40);
    ex(mbmie_pkg::OP_POP, 3'h0, 16'h0000);
    acc(32'h5A);
    flg(32'h47);
    cyc(32'h1);
  endtask
  task s_unmapped;
    logic [31:0] q;
    logic e;
    bus(1'b1, 8'h40, 32'hFFFFFFFF, q, e);
    cmp("pslverr", 32'h1, {31'h0, e});
    bus(1'b0, 8'h40, 32'h0, q, e);
    cmp("pslverr", 32'h1, {31'h0, e});
    cmp("prdata", 32'h0, q);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_compare();
    s_incdec();
    s_bits();
    s_rotate();
    s_branch();
    s_shadow();
    s_unmapped();
    summarize();
  end
endmodule

// ==== logic/mbmie_exec.sv ====
// Function
// RL1 - Compare immediate with accumulator, set zero and carry, skip when equal.
// RL2 - Memory compare behaves like immediate compare, skipping on equality.
// RL3 - Accumulator gets memory plus one, flags untouched, skip on zero.
// RL4 - Memory gets itself plus one, skip on zero, extra write cycle.
// RL5 - Accumulator gets memory minus one, flags untouched, skip on zero.
// RL6 - Memory gets itself minus one, skip when stored value is zero.
// RL7 - Skip next instruction when the selected memory bit is zero.
// RL8 - Skip next instruction when the selected memory bit is one.
// RL9 - Bank zero bit forms always address bank 0, else behave normally.
// RL10 - Jump loads low fourteen counter bits from operand, top two from page.
// RL11 - Call pushes sixteen bit counter, then loads target like jump, two cycles.
// RL12 - Interrupt return pops counter and sets global enable; plain return pops only.
// RL13 - Save copies accumulator and flags to shadows, not timeout or power-down.
// RL14 - Restore reloads accumulator and carry, decimal carry, zero from shadows.
// RL15 - Read-modify-write to data RAM costs one extra cycle, system register none.
// RL16 - Conditional skips cost one extra cycle when taken, none otherwise.
// RL17 - Rotates through carry move outgoing bit to carry, old carry in.
// RL18 - Clear zeroes byte, bit forms force one bit, no-op changes nothing.
// RL19 - Skipped instruction is fetched but never executed, no state changes.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module mbmie_exec (
  input wire logic pclk, // Clock, 250 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic global_int_en // Global interrupt enable level
);

  // Effective data address: system registers unbanked, bank zero forms forced
  function automatic logic [8:0] eff_addr(input logic [7:0] a, input logic b0, input logic bank);
    logic bk;
    bk = (b0 | a[mbmie_pkg::SYS_BIT]) ? 1'b0 : bank;
    return {bk, a};
  endfunction

  // Addresses below the system area are data RAM
  function automatic logic is_ram(input logic [7:0] a);
    return ~a[mbmie_pkg::SYS_BIT];
  endfunction

  logic [7:0] mem [0:mbmie_pkg::MEM_DEPTH-1];
  logic [15:0] stack [0:mbmie_pkg::STACK_DEPTH-1];

  logic [7:0] acc_r;
  logic [7:0] flags_r;
  logic [15:0] pc_r;
  logic [7:0] acc_sh_r;
  logic [7:0] flags_sh_r;
  logic [2:0] sp_r;
  logic bank_r;
  logic [1:0] page_r;
  logic gie_r;
  logic [8:0] maddr_r;
  logic [1:0] cnt_r;
  logic [1:0] cycles_r;
  logic skip_r;
  mbmie_pkg::mbmie_st_e st_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // APB phase decode
  wire acc_phase = psel & penable;
  wire hit_instr = paddr == mbmie_pkg::OFF_INSTR;
  wire hit_status = paddr == mbmie_pkg::OFF_STATUS;
  wire hit_acc = paddr == mbmie_pkg::OFF_ACC;
  wire hit_flags = paddr == mbmie_pkg::OFF_FLAGS;
  wire hit_pc = paddr == mbmie_pkg::OFF_PC;
  wire hit_ctrl = paddr == mbmie_pkg::OFF_CTRL;
  wire hit_maddr = paddr == mbmie_pkg::OFF_MADDR;
  wire hit_mdata = paddr == mbmie_pkg::OFF_MDATA;
  wire hit_cycles = paddr == mbmie_pkg::OFF_CYCLES;
  wire addr_ok = hit_instr | hit_status | hit_acc | hit_flags | hit_pc | hit_ctrl | hit_maddr | hit_mdata
    | hit_cycles;
  // New instructions wait while the previous one still owns its cycles
  wire hold = hit_instr & pwrite & (st_r == mbmie_pkg::ST_BUSY);
  wire commit = acc_phase & pready_r;
  wire wr_ok = commit & pwrite & addr_ok;
  wire exec = wr_ok & hit_instr;

  // Instruction fields
  wire mbmie_pkg::mbmie_op_e op = mbmie_pkg::mbmie_op_e'(pwdata[mbmie_pkg::OP_MSB:mbmie_pkg::OP_LSB]);
  wire [2:0] bsel = pwdata[mbmie_pkg::BIT_MSB:mbmie_pkg::BIT_LSB];
  wire [7:0] opnd = pwdata[7:0];
  wire [15:0] tgt = {page_r, pwdata[mbmie_pkg::TGT_MSB:0]};
  wire b0form = (op == mbmie_pkg::OP_BANK0_BIT_FORCE_LOW) | (op == mbmie_pkg::OP_BANK0_BIT_FORCE_HIGH) | (op == mbmie_pkg::OP_BANK0_BIT_TEST_SKIP_CLEAR)
    | (op == mbmie_pkg::OP_BANK0_BIT_TEST_SKIP_SET); // [RL9]
  wire [8:0] ea = eff_addr(opnd, b0form, bank_r); // [RL9]
  wire [7:0] mrd = mem[ea];
  wire ram_n = is_ram(opnd);
  wire [15:0] pc_inc = pc_r + 16'h0001;
  wire [15:0] pc_skip = pc_r + 16'h0002;
  wire [2:0] sp_dec = sp_r - 3'h1;
  wire [8:0] cmp_src = {1'b0, (op == mbmie_pkg::OP_CMP_I) ? opnd : mrd};
  wire [8:0] cmp_diff = {1'b0, acc_r} - cmp_src; // [RL1] [RL2]
  wire [7:0] inc_v = mrd + 8'h01;
  wire [7:0] dec_v = mrd - 8'h01;
  wire [7:0] bit_mask = 8'h01 << bsel;
  wire cy = flags_r[mbmie_pkg::FLG_C];

  logic [7:0] acc_nxt;
  logic [7:0] flags_nxt;
  logic [15:0] pc_nxt;
  logic [2:0] sp_nxt;
  logic gie_nxt;
  logic mem_we;
  logic [7:0] mem_wd;
  logic push_st;
  logic save_sh;
  logic skip;
  logic n_cyc;
  logic brn;

  // Execution of one instruction word; the result lands on the commit edge
  always_comb
  begin
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    sp_nxt = sp_r;
    gie_nxt = gie_r;
    mem_we = 1'b0;
    mem_wd = mrd;
    push_st = 1'b0;
    save_sh = 1'b0;
    skip = 1'b0;
    n_cyc = 1'b0;
    brn = 1'b0;
    unique case (op)
      mbmie_pkg::OP_RRC, mbmie_pkg::OP_ROTATE_RIGHT_CARRY_TO_MEM:
      begin
        flags_nxt[mbmie_pkg::FLG_C] = mrd[0]; // [RL17]
        if (op == mbmie_pkg::OP_RRC)
          acc_nxt = {cy, mrd[7:1]}; // [RL17]
        else
        begin
          mem_we = 1'b1;
          mem_wd = {cy, mrd[7:1]}; // [RL17]
          n_cyc = ram_n; // [RL15]
        end
      end
      mbmie_pkg::OP_RLC, mbmie_pkg::OP_ROTATE_LEFT_CARRY_TO_MEM:
      begin
        flags_nxt[mbmie_pkg::FLG_C] = mrd[7]; // [RL17]
        if (op == mbmie_pkg::OP_RLC)
          acc_nxt = {mrd[6:0], cy}; // [RL17]
        else
        begin
          mem_we = 1'b1;
          mem_wd = {mrd[6:0], cy}; // [RL17]
          n_cyc = ram_n; // [RL15]
        end
      end
      mbmie_pkg::OP_CLR:
      begin
        mem_we = 1'b1;
        mem_wd = 8'h00; // [RL18]
      end
      mbmie_pkg::OP_BIT_FORCE_LOW, mbmie_pkg::OP_BANK0_BIT_FORCE_LOW:
      begin
        mem_we = 1'b1;
        mem_wd = mrd & ~bit_mask; // [RL18] [RL9]
        n_cyc = ram_n; // [RL15]
      end
      mbmie_pkg::OP_BIT_FORCE_HIGH, mbmie_pkg::OP_BANK0_BIT_FORCE_HIGH:
      begin
        mem_we = 1'b1;
        mem_wd = mrd | bit_mask; // [RL18] [RL9]
        n_cyc = ram_n; // [RL15]
      end
      mbmie_pkg::OP_CMP_I, mbmie_pkg::OP_CMP_M:
      begin
        // Carry high means no borrow
        flags_nxt[mbmie_pkg::FLG_C] = ~cmp_diff[8]; // [RL1] [RL2]
        flags_nxt[mbmie_pkg::FLG_Z] = cmp_diff[7:0] == 8'h00; // [RL1] [RL2]
        skip = cmp_diff[7:0] == 8'h00; // [RL1] [RL2]
      end
      mbmie_pkg::OP_INCREMENT_ACC_SKIP_ZERO:
      begin
        acc_nxt = inc_v; // [RL3]
        skip = inc_v == 8'h00; // [RL3]
      end
      mbmie_pkg::OP_INCREMENT_MEM_SKIP_ZERO:
      begin
        mem_we = 1'b1;
        mem_wd = inc_v; // [RL4]
        skip = inc_v == 8'h00; // [RL4]
        n_cyc = ram_n; // [RL4] [RL15]
      end
      mbmie_pkg::OP_DECREMENT_ACC_SKIP_ZERO:
      begin
        acc_nxt = dec_v; // [RL5]
        skip = dec_v == 8'h00; // [RL5]
      end
      mbmie_pkg::OP_DECREMENT_MEM_SKIP_ZERO:
      begin
        mem_we = 1'b1;
        mem_wd = dec_v; // [RL6]
        skip = dec_v == 8'h00; // [RL6]
        n_cyc = ram_n; // [RL15]
      end
      mbmie_pkg::OP_BIT_TEST_SKIP_CLEAR, mbmie_pkg::OP_BANK0_BIT_TEST_SKIP_CLEAR:
        skip = ~mrd[bsel]; // [RL7] [RL9]
      mbmie_pkg::OP_BIT_TEST_SKIP_SET, mbmie_pkg::OP_BANK0_BIT_TEST_SKIP_SET:
        skip = mrd[bsel]; // [RL8] [RL9]
      mbmie_pkg::OP_JMP:
        brn = 1'b1; // [RL10]
      mbmie_pkg::OP_CALL:
      begin
        brn = 1'b1; // [RL11]
        push_st = 1'b1; // [RL11]
        sp_nxt = sp_r + 3'h1;
      end
      mbmie_pkg::OP_RET, mbmie_pkg::OP_RETURN_FROM_INTERRUPT:
      begin
        brn = 1'b1; // [RL12]
        sp_nxt = sp_dec; // [RL12]
        if (op == mbmie_pkg::OP_RETURN_FROM_INTERRUPT)
          gie_nxt = 1'b1; // [RL12]
      end
      mbmie_pkg::OP_PUSH:
        save_sh = 1'b1; // [RL13]
      mbmie_pkg::OP_POP:
      begin
        acc_nxt = acc_sh_r; // [RL14]
        flags_nxt = (flags_r & ~mbmie_pkg::FLG_SAVE_MASK) | (flags_sh_r & mbmie_pkg::FLG_SAVE_MASK); // [RL14]
      end
      default:
        acc_nxt = acc_r; // Undefined codes act as a no-op [RL18]
    endcase
  end

  // Next program counter; a taken skip steps over the next word
  always_comb
  begin
    unique case (op)
      mbmie_pkg::OP_JMP, mbmie_pkg::OP_CALL:
        pc_nxt = tgt; // [RL10] [RL11]
      mbmie_pkg::OP_RET, mbmie_pkg::OP_RETURN_FROM_INTERRUPT:
        pc_nxt = stack[sp_dec]; // [RL12]
      default:
        pc_nxt = skip ? pc_skip : pc_inc; // [RL19]
    endcase
  end

  // The skipped word's fetch is the extra cycle; nothing of it is executed
  wire [1:0] cyc_nxt = brn ? mbmie_pkg::CYC_BRANCH
    : mbmie_pkg::CYC_ONE + {1'b0, n_cyc} + {1'b0, skip}; // [RL15] [RL16] [RL19]

  // Read data selection
  wire [31:0] status_w = {25'h0, sp_r, 1'b0, gie_r, skip_r, st_r == mbmie_pkg::ST_BUSY};
  wire [31:0] rd_mux = hit_status ? status_w
    : hit_acc ? {24'h0, acc_r}
    : hit_flags ? {24'h0, flags_r}
    : hit_pc ? {16'h0, pc_r}
    : hit_ctrl ? {28'h0, gie_r, page_r, bank_r}
    : hit_maddr ? {23'h0, maddr_r}
    : hit_mdata ? {24'h0, mem[maddr_r]}
    : hit_cycles ? {30'h0, cycles_r}
    : 32'h0;

  // APB answer: one wait state, more for an instruction write while an instruction is in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= acc_phase & ~pready_r & ~hold;
      prdata_r <= (acc_phase & ~pready_r & ~hold & ~pwrite) ? rd_mux : 32'h0;
      pslverr_r <= acc_phase & ~pready_r & ~hold & ~addr_ok;
    end
  end

  // Core architectural state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r <= mbmie_pkg::ACC_RST;
      flags_r <= mbmie_pkg::FLAGS_RST;
      pc_r <= mbmie_pkg::PC_RST;
      sp_r <= 3'h0;
      gie_r <= 1'b0;
    end
    else if (exec)
    begin
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      gie_r <= gie_nxt;
    end
    else if (wr_ok)
    begin
      acc_r <= hit_acc ? pwdata[7:0] : acc_r;
      flags_r <= hit_flags ? pwdata[7:0] : flags_r;
      pc_r <= hit_pc ? pwdata[15:0] : pc_r;
      gie_r <= hit_ctrl ? pwdata[mbmie_pkg::CTL_GIE] : gie_r;
    end
  end

  // Shadow buffers leave timeout and power-down bits out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_sh_r <= mbmie_pkg::ACC_RST;
      flags_sh_r <= mbmie_pkg::FLAGS_RST;
    end
    else if (exec & save_sh)
    begin
      acc_sh_r <= acc_r; // [RL13]
      flags_sh_r <= flags_r & mbmie_pkg::FLG_SAVE_MASK; // [RL13]
    end
  end

  // Control and memory window address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_r <= 1'b0;
      page_r <= 2'h0;
      maddr_r <= 9'h0;
    end
    else if (wr_ok)
    begin
      bank_r <= hit_ctrl ? pwdata[mbmie_pkg::CTL_BANK] : bank_r;
      page_r <= hit_ctrl ? pwdata[mbmie_pkg::CTL_PG_MSB:mbmie_pkg::CTL_PG_LSB] : page_r;
      maddr_r <= hit_maddr ? pwdata[8:0] : maddr_r;
    end
  end

  // Cycle accounting; an instruction owns the core for its whole count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= mbmie_pkg::ST_IDLE;
      cnt_r <= 2'h0;
      cycles_r <= 2'h0;
      skip_r <= 1'b0;
    end
    else if (exec)
    begin
      cycles_r <= cyc_nxt; // [RL15] [RL16]
      skip_r <= skip;
      cnt_r <= cyc_nxt - 2'h1;
      st_r <= (cyc_nxt == mbmie_pkg::CYC_ONE) ? mbmie_pkg::ST_IDLE : mbmie_pkg::ST_BUSY;
    end
    else
    begin
      unique case (st_r)
        mbmie_pkg::ST_IDLE:
          cnt_r <= 2'h0;
        mbmie_pkg::ST_BUSY:
        begin
          cnt_r <= cnt_r - 2'h1;
          st_r <= (cnt_r == 2'h1) ? mbmie_pkg::ST_IDLE : mbmie_pkg::ST_BUSY;
        end
      endcase
    end
  end

  // Data memory and stack have no reset; software initialises them
  always_ff @(posedge pclk)
  begin
    if (exec & mem_we)
      mem[ea] <= mem_wd; // [RL4] [RL6] [RL18]
    else if (wr_ok & hit_mdata)
      mem[maddr_r] <= pwdata[7:0];
    if (exec & push_st)
      stack[sp_r] <= pc_inc; // [RL11]
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign global_int_en = gie_r;

endmodule

// ==== logic/mbmie_pkg.sv ====
package mbmie_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_MADDR = 8'h18;
  localparam logic [7:0] OFF_MDATA = 8'h1C;
  localparam logic [7:0] OFF_CYCLES = 8'h20;

  // Instruction word layout
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 27;
  localparam int BIT_MSB = 26;
  localparam int BIT_LSB = 24;
  localparam int OPND_MSB = 15;
  localparam int TGT_MSB = 13;

  // Flag register layout
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_NPD = 6;
  localparam int FLG_NT0 = 7;
  localparam logic [7:0] FLG_SAVE_MASK = 8'h07;

  // Control register layout
  localparam int CTL_BANK = 0;
  localparam int CTL_PG_LSB = 1;
  localparam int CTL_PG_MSB = 2;
  localparam int CTL_GIE = 3;

  // Status register layout
  localparam int STS_BUSY = 0;
  localparam int STS_SKIP = 1;
  localparam int STS_GIE = 2;
  localparam int STS_SP_LSB = 4;
  localparam int STS_SP_MSB = 6;

  // Address space: bit 7 set selects the system registers
  localparam int SYS_BIT = 7;
  localparam int MEM_DEPTH = 512;
  localparam int STACK_DEPTH = 8;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;

  // Cycle figures in instruction cycles, one pclk each
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_BRANCH = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_RRC = 5'h01,
    OP_ROTATE_RIGHT_CARRY_TO_MEM = 5'h02,
    OP_RLC = 5'h03,
    OP_ROTATE_LEFT_CARRY_TO_MEM = 5'h04,
    OP_CLR = 5'h05,
    OP_BIT_FORCE_LOW = 5'h06,
    OP_BIT_FORCE_HIGH = 5'h07,
    OP_BANK0_BIT_FORCE_LOW = 5'h08,
    OP_BANK0_BIT_FORCE_HIGH = 5'h09,
    OP_CMP_I = 5'h0A,
    OP_CMP_M = 5'h0B,
    OP_INCREMENT_ACC_SKIP_ZERO = 5'h0C,
    OP_INCREMENT_MEM_SKIP_ZERO = 5'h0D,
    OP_DECREMENT_ACC_SKIP_ZERO = 5'h0E,
    OP_DECREMENT_MEM_SKIP_ZERO = 5'h0F,
    OP_BIT_TEST_SKIP_CLEAR = 5'h10,
    OP_BIT_TEST_SKIP_SET = 5'h11,
    OP_BANK0_BIT_TEST_SKIP_CLEAR = 5'h12,
    OP_BANK0_BIT_TEST_SKIP_SET = 5'h13,
    OP_JMP = 5'h14,
    OP_CALL = 5'h15,
    OP_RET = 5'h16,
    OP_RETURN_FROM_INTERRUPT = 5'h17,
    OP_PUSH = 5'h18,
    OP_POP = 5'h19
  } mbmie_op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } mbmie_st_e;

endpackage
